// ==== hw/rph_regs.svh ====
// constants of the radio packet handler
`ifndef RPH_REGS_SVH
`define RPH_REGS_SVH
`define RPH_CRC_POLY    16'h1021
`define RPH_CRC_INIT    16'hFFFF
`define RPH_FILLER      8'hAA
`define RPH_BCAST_LO    8'h00
`define RPH_BCAST_HI    8'hFF
`define RPH_FIFO_UNIT   7'h10
`define RPH_FILT_OFF    2'h0
`define RPH_FILT_ALL    2'h3
`endif

// ==== hw/rph_pkg.sv ====
// state types of the radio packet handler
package rph_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_PAY, TX_CRC, TX_DONE} rph_tx_state_t;
  typedef enum logic [1:0] {RX_WAIT, RX_HUNT, RX_PAY, RX_CRC} rph_rx_state_t;
endpackage

// ==== hw/rph_packet_handler.sv ====
// packet framer, deframer, payload fifo and link serialiser
//
// Summary of operation
// R1: frame_format_select picks fixed or variable length frames.
// R2: frame length is clamped to the selected fifo depth of 16 to 64 bytes.
// R3: fixed frames carry payload_length_setting bytes, at least one, same on all nodes.
// R4: variable frames: first byte is length; frame holds at least one byte.
// R5: the length byte of a variable frame is left out of the crc.
// R6: transmit sends preamble bytes, sync word, payload, optional crc and coding.
// R7: transmit starts on first byte or on reaching the fifo threshold.
// R8: fifo may be filled or emptied in standby; start checked on entering transmit.
// R9: host must leave transmit mode itself after the done event.
// R10: filler preamble is sent when idle; the current filler byte always completes.
// R11: receive strips preamble, sync and crc; payload with length/address goes to fifo.
// R12: frame end raises payload ready, and crc good when checking is on.
// R13: autoclear on: crc failure flushes fifo, no events, hunts again.
// R14: autoclear off: crc failure keeps fifo and raises payload ready only.
// R15: after a frame filling stops; new hunt only once the fifo is empty.
// R16: frames without matching sync word are dropped silently.
// R17: sync detection starts payload reception and raises the sync event.
// R18: variable frame accepted only if length byte below the programmed maximum.
// R19: address filters: 01 node only, 10 adds 0x00, 11 adds 0x00 and 0xFF.
// R20: node address and filter act on receive only; address stays in fifo.
// R21: crc enable: 16-bit crc appended on transmit, compared on receive.
// R22: receive crc outcome is held in crc_result_status.
// R23: packet mode forces bit synchroniser and sync recognition on.
// R24: address filter 00 turns address checking off.
// R25: crc polynomial 0x1021, initial value all ones, msb first.
// R26: manchester codes one as 10 and zero as 01 on payload and crc only.
`timescale 1ns/100ps
`include "rph_regs.svh"
module rph_packet_handler #(
  parameter int FIFO_MAX = 64,
  parameter int PRE_W    = 8
) (
  // clocks and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               clk_link,
  // modes
  input  wire logic               packet_mode,
  input  wire logic               mode_tx,
  input  wire logic               mode_rx,
  input  wire logic               fifo_standby_access,
  // configuration
  input  wire logic               frame_format_select,
  input  wire logic [6:0]         payload_length_setting,
  input  wire logic [1:0]         fifo_size_select,
  input  wire logic [5:0]         fifo_threshold,
  input  wire logic               tx_start_condition,
  input  wire logic [PRE_W-1:0]   preamble_byte_count,
  input  wire logic               crc_check_enable,
  input  wire logic               crc_fail_autoclear_disable,
  input  wire logic [1:0]         address_filter_select,
  input  wire logic [7:0]         node_address_value,
  input  wire logic               manchester_enable,
  input  wire logic               sync_recognition_enable,
  input  wire logic               bit_sync_setting,
  input  wire logic [1:0]         sync_word_size,
  input  wire logic [1:0]         sync_error_tolerance,
  input  wire logic [31:0]        sync_word_value,
  // host fifo access
  input  wire logic               fifo_wr_en,
  input  wire logic [7:0]         fifo_wr_data,
  input  wire logic               fifo_rd_en,
  output logic      [7:0]         fifo_rd_data,
  output logic                    fifo_empty,
  output logic                    fifo_full,
  // events and status
  output logic                    tx_done_event,
  output logic                    payload_ready_event,
  output logic                    crc_good_event,
  output logic                    sync_detected_event,
  output logic                    crc_result_status,
  output logic                    bit_sync_active,
  output logic                    sync_recognition_active,
  // link
  output logic                    tx_chip,
  input  wire logic               rx_chip_in
);
  localparam int AW = $clog2(FIFO_MAX);
  localparam int CW = AW + 1;

  generate
    if (FIFO_MAX < 64 || (1 << AW) != FIFO_MAX) begin : g_bad_depth
      $error("FIFO_MAX must be a power of two of at least 64");
    end
  endgenerate

  function automatic logic [15:0] rph_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `RPH_CRC_POLY) : {r[14:0], 1'b0}; // R25
    end
    return r;
  endfunction

  // length limited to the selected depth
  function automatic logic [7:0] rph_clamp(input logic [8:0] l, input logic [6:0] cap);
    return (l > {2'h0, cap}) ? {1'b0, cap} : l[7:0];
  endfunction

  function automatic logic rph_sync_hit(input logic [31:0] hist, input logic [31:0] word,
                                        input logic [1:0] size, input logic [1:0] tol);
    logic [31:0] ref_w;
    logic [5:0]  n;
    logic [5:0]  miss;
    ref_w = word >> {~size, 3'h0};
    n     = {{1'b0, size} + 3'h1, 3'h0};
    miss  = 6'h0;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < n) begin
        miss = miss + {5'h0, hist[i] ^ ref_w[i]};
      end
    end
    return miss <= {4'h0, tol};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // payload fifo
  logic [7:0]                 mem [FIFO_MAX];
  logic [AW:0]                wr_ptr;
  logic [AW:0]                rd_ptr;
  logic [CW-1:0]              fifo_count;
  logic [6:0]                 cap;
  logic [7:0]                 fifo_head;
  logic                       host_wr_ok;
  logic                       host_rd_ok;
  logic                       tx_pop;
  logic                       rx_push;
  logic                       rx_flush;
  logic                       push;
  logic [7:0]                 push_data;
  logic [7:0]                 rx_byte;

  assign cap        = 7'(({1'b0, fifo_size_select} + 3'h1) * `RPH_FIFO_UNIT); // R2
  assign fifo_count = wr_ptr - rd_ptr;
  assign fifo_empty = (fifo_count == '0);
  assign fifo_full  = (fifo_count >= CW'(cap)); // R2
  assign fifo_head  = mem[rd_ptr[AW-1:0]];
  assign host_wr_ok = fifo_wr_en & ~fifo_full & (mode_tx | (fifo_standby_access & ~mode_rx)); // R8
  assign host_rd_ok = fifo_rd_en & ~fifo_empty & ~mode_tx & (mode_rx | fifo_standby_access); // R8
  assign push       = host_wr_ok | rx_push;
  assign push_data  = rx_push ? rx_byte : fifo_wr_data;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= push_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (rx_flush) begin
      rd_ptr <= wr_ptr; // R13
    end else if (host_rd_ok | tx_pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fifo_rd_data <= 8'h00;
    end else if (host_rd_ok) begin
      fifo_rd_data <= fifo_head;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_sync_active         <= 1'b0;
      sync_recognition_active <= 1'b0;
    end else begin
      bit_sync_active         <= packet_mode | bit_sync_setting; // R23
      sync_recognition_active <= packet_mode | sync_recognition_enable; // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // crossings into the system domain
  logic tx_req;
  logic tx_ack;
  logic tx_ack_1;
  logic tx_ack_s;
  logic rx_sync_tgl;
  logic rx_sync_1;
  logic rx_sync_s;
  logic rx_sync_d;
  logic rx_byte_tgl;
  logic rx_byte_1;
  logic rx_byte_s;
  logic rx_byte_d;
  logic sync_pulse;
  logic byte_pulse;
  logic tx_free;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {tx_ack_1, tx_ack_s}             <= 2'h0;
      {rx_sync_1, rx_sync_s, rx_sync_d} <= 3'h0;
      {rx_byte_1, rx_byte_s, rx_byte_d} <= 3'h0;
    end else begin
      {tx_ack_1, tx_ack_s}             <= {tx_ack, tx_ack_1};
      {rx_sync_1, rx_sync_s, rx_sync_d} <= {rx_sync_tgl, rx_sync_1, rx_sync_s};
      {rx_byte_1, rx_byte_s, rx_byte_d} <= {rx_byte_tgl, rx_byte_1, rx_byte_s};
    end
  end

  assign sync_pulse = rx_sync_s ^ rx_sync_d;
  assign byte_pulse = rx_byte_s ^ rx_byte_d;
  assign tx_free    = (tx_req == tx_ack_s);

  ////////////////////////////////////////////////////////////////////////////////
  // transmit framer
  rph_pkg::rph_tx_state_t tx_state;
  logic [7:0]             tx_cnt;
  logic [7:0]             tx_len;
  logic [7:0]             tx_len_now;
  logic [15:0]            tx_crc;
  logic [7:0]             tx_byte;
  logic                   tx_manch;
  logic                   tx_start_ok;
  logic                   tx_is_len;

  // a prefilled fifo meets the condition at once on entering transmit
  assign tx_start_ok = tx_start_condition ? ~fifo_empty
                                          : (fifo_count >= CW'(fifo_threshold)); // R7 R8
  assign tx_is_len   = frame_format_select & (tx_cnt == 8'h00); // R1
  assign tx_len_now  = tx_is_len ? rph_clamp({1'b0, fifo_head} + 9'h1, cap) : tx_len; // R4
  assign tx_pop      = mode_tx & (tx_state == rph_pkg::TX_PAY) & tx_free & ~fifo_empty;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_state      <= rph_pkg::TX_IDLE;
      tx_cnt        <= 8'h00;
      tx_len        <= 8'h00;
      tx_crc        <= `RPH_CRC_INIT;
      tx_byte       <= `RPH_FILLER;
      tx_manch      <= 1'b0;
      tx_req        <= 1'b0;
      tx_done_event <= 1'b0;
    end else begin
      tx_done_event <= 1'b0;
      if (!mode_tx) begin
        tx_state <= rph_pkg::TX_IDLE; // R9
      end else begin
        unique case (tx_state)
          rph_pkg::TX_IDLE: begin
            if (tx_start_ok) begin // R7
              tx_state <= rph_pkg::TX_PRE;
              tx_cnt   <= 8'h00;
              tx_len   <= rph_clamp({2'h0, payload_length_setting}, cap); // R3
            end
          end
          rph_pkg::TX_PRE: begin
            if (tx_free) begin
              tx_byte  <= `RPH_FILLER; // R6
              tx_manch <= 1'b0;
              tx_req   <= ~tx_req;
              tx_cnt   <= tx_cnt + 8'h01;
              if (PRE_W'(tx_cnt + 8'h01) >= preamble_byte_count) begin
                tx_state <= rph_pkg::TX_SYNC;
                tx_cnt   <= 8'h00;
              end
            end
          end
          rph_pkg::TX_SYNC: begin
            if (tx_free) begin
              tx_byte  <= sync_word_value[5'd31 - {tx_cnt[1:0], 3'h0} -: 8]; // R6
              tx_manch <= 1'b0; // R26
              tx_req   <= ~tx_req;
              tx_cnt   <= tx_cnt + 8'h01;
              if (tx_cnt[1:0] == sync_word_size) begin
                tx_state <= rph_pkg::TX_PAY;
                tx_cnt   <= 8'h00;
                tx_crc   <= `RPH_CRC_INIT;
              end
            end
          end
          rph_pkg::TX_PAY: begin
            if (tx_free && !fifo_empty) begin
              tx_byte  <= fifo_head;
              tx_manch <= manchester_enable; // R26
              tx_req   <= ~tx_req;
              tx_cnt   <= tx_cnt + 8'h01;
              tx_len   <= tx_len_now;
              if (!tx_is_len) begin
                tx_crc <= rph_crc_byte(tx_crc, fifo_head); // R5 R21
              end
              if (tx_cnt + 8'h01 >= tx_len_now) begin // R3 R4
                tx_state <= crc_check_enable ? rph_pkg::TX_CRC : rph_pkg::TX_DONE;
                tx_cnt   <= 8'h00;
              end
            end
          end
          rph_pkg::TX_CRC: begin
            if (tx_free) begin
              tx_byte  <= tx_cnt[0] ? tx_crc[7:0] : tx_crc[15:8]; // R21
              tx_manch <= manchester_enable;
              tx_req   <= ~tx_req;
              tx_cnt   <= tx_cnt + 8'h01;
              if (tx_cnt[0]) begin
                tx_state <= rph_pkg::TX_DONE;
              end
            end
          end
          rph_pkg::TX_DONE: begin
            if (tx_free) begin
              tx_done_event <= 1'b1;
              tx_state      <= rph_pkg::TX_IDLE; // R10
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive deframer
  rph_pkg::rph_rx_state_t rx_state;
  logic [7:0]             rx_cnt;
  logic [7:0]             rx_len;
  logic [7:0]             rx_len_now;
  logic [15:0]            rx_crc;
  logic [7:0]             rx_crc_hi;
  logic                   rx_arm;
  logic                   rx_is_len;
  logic                   rx_addr_ok;
  logic                   rx_reject;
  logic                   rx_last;
  logic                   rx_crc_good;

  always_comb begin
    rx_is_len   = frame_format_select & (rx_cnt == 8'h00);
    rx_addr_ok  = (rx_byte == node_address_value)
                | (address_filter_select[1] & (rx_byte == `RPH_BCAST_LO))
                | ((address_filter_select == `RPH_FILT_ALL) & (rx_byte == `RPH_BCAST_HI)); // R19
    rx_reject   = (rx_is_len & ({1'b0, payload_length_setting} <= rx_byte)) // R18
                | ((address_filter_select != `RPH_FILT_OFF) // R24
                  & (rx_cnt == {7'h00, frame_format_select}) & ~rx_addr_ok); // R19 R20
    rx_len_now  = rx_is_len ? rph_clamp({1'b0, rx_byte} + 9'h1, cap) : rx_len;
    rx_last     = (rx_cnt + 8'h01 >= rx_len_now);
    rx_crc_good = ({rx_crc_hi, rx_byte} == rx_crc); // R21
    rx_push     = mode_rx & (rx_state == rph_pkg::RX_PAY) & byte_pulse & ~rx_reject
                & ~fifo_full; // R11
    rx_flush    = mode_rx & byte_pulse
                & (((rx_state == rph_pkg::RX_PAY) & rx_reject)
                  | ((rx_state == rph_pkg::RX_CRC) & rx_cnt[0] & ~rx_crc_good
                    & ~crc_fail_autoclear_disable)); // R13 R14
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_state            <= rph_pkg::RX_WAIT;
      rx_cnt              <= 8'h00;
      rx_len              <= 8'h00;
      rx_crc              <= `RPH_CRC_INIT;
      rx_crc_hi           <= 8'h00;
      crc_result_status   <= 1'b0;
      payload_ready_event <= 1'b0;
      crc_good_event      <= 1'b0;
      sync_detected_event <= 1'b0;
    end else begin
      payload_ready_event <= 1'b0;
      crc_good_event      <= 1'b0;
      sync_detected_event <= 1'b0;
      if (!mode_rx) begin
        rx_state <= rph_pkg::RX_WAIT;
      end else begin
        unique case (rx_state)
          rph_pkg::RX_WAIT: begin
            if (fifo_empty) begin
              rx_state <= rph_pkg::RX_HUNT; // R15
            end
          end
          rph_pkg::RX_HUNT: begin
            if (sync_pulse) begin // R16 R17
              rx_state            <= rph_pkg::RX_PAY;
              rx_cnt              <= 8'h00;
              rx_crc              <= `RPH_CRC_INIT;
              rx_len              <= rph_clamp({2'h0, payload_length_setting}, cap); // R3
              sync_detected_event <= 1'b1; // R17
            end
          end
          rph_pkg::RX_PAY: begin
            if (byte_pulse) begin
              if (rx_reject) begin
                rx_state <= rph_pkg::RX_WAIT;
              end else begin
                rx_cnt <= rx_cnt + 8'h01;
                rx_len <= rx_len_now;
                if (!rx_is_len) begin
                  rx_crc <= rph_crc_byte(rx_crc, rx_byte); // R5
                end
                if (rx_last) begin
                  rx_cnt <= 8'h00;
                  if (crc_check_enable) begin
                    rx_state <= rph_pkg::RX_CRC;
                  end else begin
                    payload_ready_event <= 1'b1; // R12
                    rx_state            <= rph_pkg::RX_WAIT; // R15
                  end
                end
              end
            end
          end
          rph_pkg::RX_CRC: begin
            if (byte_pulse) begin
              rx_cnt <= rx_cnt + 8'h01;
              if (!rx_cnt[0]) begin
                rx_crc_hi <= rx_byte; // R11
              end else begin
                crc_result_status <= rx_crc_good; // R22
                if (rx_crc_good || crc_fail_autoclear_disable) begin
                  payload_ready_event <= 1'b1; // R12 R14
                  crc_good_event      <= rx_crc_good; // R12
                end
                rx_state <= rph_pkg::RX_WAIT; // R13 R15
              end
            end
          end
        endcase
      end
    end
  end

  // low for at least one cycle between frames so the link drops its byte collection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_arm <= 1'b0;
    end else begin
      rx_arm <= mode_rx & (rx_state != rph_pkg::RX_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: synchronisers
  logic        rst_l1;
  logic        rst_l;
  logic        req_l1;
  logic        req_l;
  logic        arm_l1;
  logic        arm_l;
  logic        man_l1;
  logic        man_l;
  logic [35:0] cfg_l1;
  logic [35:0] cfg_l;
  logic        rxi_1;
  logic        rxi;

  // configuration is quasi static; a change mid-frame may be seen torn
  always_ff @(posedge clk_link) begin
    {rst_l1, rst_l} <= {rst, rst_l1};
    {req_l1, req_l} <= {tx_req, req_l1};
    {arm_l1, arm_l} <= {rx_arm, arm_l1};
    {man_l1, man_l} <= {manchester_enable, man_l1};
    {rxi_1, rxi}    <= {rx_chip_in, rxi_1};
    cfg_l1          <= {sync_word_size, sync_error_tolerance, sync_word_value};
    cfg_l           <= cfg_l1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: transmit serialiser
  logic [7:0] ltx_sh;
  logic [2:0] ltx_bit;
  logic       ltx_half;
  logic       ltx_man;
  logic [8:0] ltx_hold;
  logic       ltx_have;

  always_ff @(posedge clk_link) begin
    if (rst_l) begin
      ltx_sh   <= `RPH_FILLER;
      ltx_bit  <= 3'h0;
      ltx_half <= 1'b0;
      ltx_man  <= 1'b0;
      tx_ack   <= 1'b0;
      tx_chip  <= 1'b0;
      ltx_hold <= 9'h000;
      ltx_have <= 1'b0;
    end else begin
      tx_chip <= ltx_man ? (ltx_sh[7] ^ ltx_half) : ltx_sh[7]; // R26
      // take an offered byte at once: the ack round trip outlasts one slot
      if (req_l != tx_ack && !ltx_have) begin
        ltx_hold <= {tx_manch, tx_byte};
        ltx_have <= 1'b1;
        tx_ack   <= req_l;
      end
      if (ltx_man && !ltx_half) begin
        ltx_half <= 1'b1;
      end else begin
        ltx_half <= 1'b0;
        ltx_bit  <= ltx_bit + 3'h1;
        ltx_sh   <= {ltx_sh[6:0], 1'b0};
        if (ltx_bit == 3'h7) begin // R10
          if (ltx_have) begin
            ltx_sh   <= ltx_hold[7:0];
            ltx_man  <= ltx_hold[8];
            ltx_have <= 1'b0;
          end else begin
            ltx_sh  <= `RPH_FILLER; // R10
            ltx_man <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: sync search and receive deserialiser
  logic [31:0] lrx_hist;
  logic        lrx_col;
  logic [2:0]  lrx_bit;
  logic        lrx_half;
  logic [6:0]  lrx_acc;

  always_ff @(posedge clk_link) begin
    if (rst_l) begin
      lrx_hist    <= 32'h0000_0000;
      lrx_col     <= 1'b0;
      lrx_bit     <= 3'h0;
      lrx_half    <= 1'b0;
      lrx_acc     <= 7'h00;
      rx_byte     <= 8'h00;
      rx_byte_tgl <= 1'b0;
      rx_sync_tgl <= 1'b0;
    end else begin
      lrx_hist <= {lrx_hist[30:0], rxi};
      if (!arm_l) begin
        lrx_col <= 1'b0;
      end else if (!lrx_col) begin
        if (rph_sync_hit({lrx_hist[30:0], rxi}, cfg_l[31:0], cfg_l[35:34], cfg_l[33:32])) begin
          lrx_col     <= 1'b1; // R11 R16
          lrx_bit     <= 3'h0;
          lrx_half    <= 1'b0;
          rx_sync_tgl <= ~rx_sync_tgl; // R17
        end
      end else begin
        // first chip of a manchester pair carries the data value
        lrx_half <= man_l & ~lrx_half; // R26
        if (!man_l || !lrx_half) begin
          lrx_acc <= {lrx_acc[5:0], rxi};
          lrx_bit <= lrx_bit + 3'h1;
          if (lrx_bit == 3'h7) begin
            rx_byte     <= {lrx_acc, rxi};
            rx_byte_tgl <= ~rx_byte_tgl;
          end
        end
      end
    end
  end
endmodule

// ==== verification/rph_props.sv ====
// assertion checker of the radio packet handler
`timescale 1ns/100ps
module rph_props (
  // clock and modes
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       packet_mode,
  input wire logic       mode_tx,
  input wire logic       mode_rx,
  input wire logic       fifo_standby_access,
  input wire logic       crc_check_enable,
  // fifo
  input wire logic       fifo_wr_en,
  input wire logic       fifo_rd_en,
  input wire logic [7:0] fifo_rd_data,
  input wire logic       fifo_empty,
  // events and status
  input wire logic       tx_done_event,
  input wire logic       payload_ready_event,
  input wire logic       crc_good_event,
  input wire logic       crc_result_status,
  input wire logic       bit_sync_active,
  input wire logic       sync_recognition_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_good_end;
    crc_good_event && payload_ready_event;
  endsequence
  sequence s_standby_wr;
    fifo_wr_en && fifo_empty && fifo_standby_access && !mode_tx && !mode_rx;
  endsequence
  a_sync_forced: assert property (packet_mode |=> sync_recognition_active)
    else $error("sync recognition not forced");
  a_bitsync_forced: assert property (packet_mode |=> bit_sync_active)
    else $error("bit sync not forced");
  a_good_pairs: assert property (crc_good_event |-> s_good_end)
    else $error("crc good without payload ready");
  a_good_enable: assert property (crc_good_event |-> crc_check_enable)
    else $error("crc good with checking off");
  a_good_status: assert property (crc_good_event |-> ##[0:1] crc_result_status)
    else $error("crc status not set");
  a_ready_pulse: assert property (payload_ready_event |=> !payload_ready_event)
    else $error("payload ready not a pulse");
  a_done_in_tx: assert property (tx_done_event |-> $past(mode_tx))
    else $error("tx done outside transmit");
  a_standby_write: assert property (s_standby_wr |=> !fifo_empty)
    else $error("standby write lost");
  a_refused_read: assert property (fifo_rd_en && (fifo_empty || mode_tx)
    |=> $stable(fifo_rd_data))
    else $error("refused read changed data");
endmodule
bind rph_packet_handler rph_props props_u (.*);

// ==== verification/rph_peer.sv ====
// far-end radio driving the receive chip line
`timescale 1ns/100ps
module rph_peer (
  // link
  input  wire logic clk_link,
  output logic      rx_chip
);
  logic idle_bit = 1'b0;
  logic busy     = 1'b0;
  initial rx_chip = 1'b0;
  // idle line toggles so a stale level never reads as data
  always @(negedge clk_link) begin
    idle_bit <= ~idle_bit;
    if (!busy) rx_chip <= idle_bit;
  end
  task automatic send(input logic [7:0] q[$]);
    busy = 1'b1;
    foreach (q[i])
      for (int b = 7; b >= 0; b--) begin
        @(negedge clk_link);
        rx_chip <= q[i][b];
      end
    @(negedge clk_link);
    busy = 1'b0;
  endtask
endmodule

// ==== verification/test_radio_packet_handler.sv ====
// self-checking bench of the radio packet handler
`timescale 1ns/100ps
module test_radio_packet_handler;
  logic        clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, packet_mode = 1'b1;
  logic        mode_tx = 1'b0, mode_rx = 1'b0, fifo_standby_access = 1'b0;
  logic        frame_format_select = 1'b0, tx_start_condition = 1'b1;
  logic        crc_check_enable = 1'b1, crc_fail_autoclear_disable = 1'b0;
  logic        manchester_enable = 1'b0, sync_recognition_enable = 1'b0;
  logic        bit_sync_setting = 1'b0, fifo_wr_en = 1'b0, fifo_rd_en = 1'b0, rx_chip_in;
  logic [6:0]  payload_length_setting = 7'h04;
  logic [1:0]  fifo_size_select = 2'h0, address_filter_select = 2'h0;
  logic [1:0]  sync_word_size = 2'h1, sync_error_tolerance = 2'h0;
  logic [5:0]  fifo_threshold = 6'h04;
  logic [7:0]  preamble_byte_count = 8'h02, node_address_value = 8'h5A;
  logic [31:0] sync_word_value = 32'hD3910000;
  logic [7:0]  fifo_wr_data = 8'h00, fifo_rd_data;
  logic        fifo_empty, fifo_full, tx_done_event, payload_ready_event, crc_good_event;
  logic        sync_detected_event, crc_result_status, bit_sync_active;
  logic        sync_recognition_active, tx_chip;
  int          failures = 0, compares = 0, n_ready = 0, n_good = 0, n_sync = 0, n_done = 0;
  logic [7:0]  pay [$];
  logic [47:0] tx_hist = '0;
  logic [31:0] tx_seen = '0;
  rph_packet_handler dut_u (.*);
  rph_peer peer_u (.clk_link(clk_link), .rx_chip(rx_chip_in));
  always #50 clk_sys = ~clk_sys;
  always #24 clk_link = ~clk_link;
  always @(negedge clk_link) begin
    tx_hist <= {tx_hist[46:0], tx_chip};
    if (tx_hist[47:32] == 16'hD391 && tx_seen == '0) tx_seen <= tx_hist[31:0];
  end
  always @(posedge clk_sys) begin
    if (payload_ready_event === 1'b1) n_ready++;
    if (crc_good_event === 1'b1) n_good++;
    if (sync_detected_event === 1'b1) n_sync++;
    if (tx_done_event === 1'b1) n_done++;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i])
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic rx_frame(input logic [7:0] flip);
    logic [7:0]  f [$];
    logic [15:0] c;
    c = crc16(pay);
    f = {8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hD3, 8'h91};
    f = {f, pay, c[15:8], c[7:0] ^ flip};
    peer_u.send(f);
    repeat (30) @(negedge clk_sys);
  endtask
  // fifth read hits an empty fifo, so the last byte must stand
  task automatic rd_all();
    @(negedge clk_sys) fifo_rd_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys);
      chk(fifo_rd_data, pay[i > 3 ? 3 : i]);
    end
    fifo_rd_en = 1'b0;
  endtask
  task automatic test_done();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #1_000_000;
    failures++;
    test_done();
  end
  initial begin
    void'($urandom(23));
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) pay.push_back(8'($urandom));
    mode_rx = 1'b1;
    rx_frame(8'h00);
    chk(n_sync, 1);
    chk(n_good, 1);
    chk(crc_result_status, 1);
    rx_frame(8'h00);
    chk(n_ready, 1);
    rd_all();
    chk(fifo_empty, 1);
    pay = {};
    repeat (4) pay.push_back(8'($urandom));
    rx_frame(8'h01);
    chk(n_sync, 2);
    chk(n_ready, 1);
    chk(fifo_empty, 1);
    chk(crc_result_status, 0);
    crc_fail_autoclear_disable = 1'b1;
    rx_frame(8'h01);
    chk(n_ready, 2);
    chk(n_good, 1);
    rd_all();
    mode_rx = 1'b0;
    fifo_standby_access = 1'b1;
    preamble_byte_count = 8'($urandom_range(1, 3));
    fifo_wr_en = 1'b1;
    foreach (pay[i]) begin
      pay[i]       = 8'($urandom);
      fifo_wr_data = pay[i];
      @(negedge clk_sys);
    end
    fifo_wr_en = 1'b0;
    chk(fifo_empty, 0);
    mode_tx = 1'b1;
    for (int i = 0; i < 300 && n_done == 0; i++) @(negedge clk_sys);
    chk(n_done, 1);
    chk(fifo_empty, 1);
    chk(tx_seen, {pay[0], pay[1], pay[2], pay[3]});
    mode_tx = 1'b0;
    test_done();
  end
endmodule
